// file: isl_pkg.sv
package isl_pkg;
  // Address layout and protocol constants
  localparam int unsigned ADDR_W        = 10;
  localparam int unsigned BYTE_W        = 8;
  localparam logic [4:0]  HDR10_PATTERN = 5'h1E;   // 11110 header
  localparam logic [3:0]  BITS_PER_BYTE = 4'h8;
  localparam logic [3:0]  ACK_BIT_IDX   = 4'h9;
  // Reset values
  localparam logic [7:0]  RESET_BYTE    = 8'h00;
  localparam logic [9:0]  RESET_ADDR    = 10'h000;
  // Control word bit positions
  localparam int unsigned CTL_EN_POS    = 15;
  localparam int unsigned CTL_A10_POS   = 10;
  localparam int unsigned CTL_REL_POS   = 12;
  // Synchroniser depth on sampled pins
  localparam int unsigned SYNC_STAGES   = 2;
endpackage

// file: isl_sync.sv
`timescale 1ns/100ps
// Two-flop synchroniser with edge pulses taken from the settled stages
module isl_sync (
  input  wire logic clk_i,
  input  wire logic srst_i,
  input  wire logic pin_i,
  output logic      level_o,
  output logic      rise_o,
  output logic      fall_o
);
  import isl_pkg::*;

  typedef struct packed {
    logic meta;
    logic sync;
    logic prev;
  } isl_sync_t;

  isl_sync_t st;
  isl_sync_t next_st;

  // First stage feeds only the second; edges use stages two and three
  always_comb begin
    next_st      = st;
    next_st.meta = pin_i;
    next_st.sync = st.meta;
    next_st.prev = st.sync;
  end

  // Bus idles high, so reset to one to avoid a false start
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      st <= 3'b111;
    end else begin
      st <= next_st;
    end
  end

  assign level_o = st.sync;
  assign rise_o  = st.sync & ~st.prev;
  assign fall_o  = ~st.sync & st.prev;
endmodule // isl_sync

// file: isl_slave.sv
`timescale 1ns/100ps
// Notes on behaviour
// - When enabled, wait idle for a Start before shifting an address byte.
// - After Start shift eight bits, then compare with own address.
// - 7-bit mode compares own bits 6:0 with shift bits 7:1; bit0 is R_W.
// - Every incoming bit is sampled on the rising SCL edge.
// - On match drive acknowledge, set slave event on ninth falling edge.
// - Address match leaves receive buffer and full flag untouched.
// - R_W one enters transmit, acknowledges, holds SCL low until load.
// - Software sets clock release to free SCL; eight bits then go out.
// - Transmit data changes on SCL falling edge, stable while SCL high.
// - Transmit raises event pulse on ninth falling edge regardless of ACK.
// - R_W zero receives; byte loads buffer and acknowledges when clear.
// - Full buffer at byte end: no ACK, event pulse, buffer not loaded.
// - Overflow set with buffer empty: load buffer but answer NACK.
// - Shift and buffer registers double-buffer reception; no transmit buffer.
// - Width select at control bit 10; zero means 7-bit compare.
// - 10-bit header is 11110 A9 A8; next byte compares own bits 7:0.
// - After repeated Start in 10-bit mode only a read header must match.
// - The own address register holds ten bits.
// - Control fully writable; status low six bits read-only.
// - Clock release cleared holds SCL low until software sets it again.
module isl_slave (
  input  wire logic                          clk_i,
  input  wire logic                          srst_i,
  input  wire logic                          scl_i,
  input  wire logic                          sda_i,
  output logic                               scl_o,
  output logic                               scl_oe_o,
  output logic                               sda_o,
  output logic                               sda_oe_o,
  input  wire logic                          module_enable_bit_i,
  input  wire logic                          address_width_select_i,
  input  wire logic [isl_pkg::ADDR_W-1:0]    own_address_reg_i,
  input  wire logic                          own_address_we_i,
  input  wire logic [isl_pkg::BYTE_W-1:0]    transmit_holding_reg_i,
  input  wire logic                          transmit_we_i,
  input  wire logic                          clock_release_set_i,
  input  wire logic                          receive_read_i,
  input  wire logic                          overflow_clear_i,
  output logic [isl_pkg::BYTE_W-1:0]         receive_buffer_reg_o,
  output logic                               receive_full_flag_o,
  output logic                               receive_overflow_flag_o,
  output logic                               wide_address_match_flag_o,
  output logic                               slave_event_flag_o,
  output logic                               transmit_mode_o,
  output logic                               clock_release_bit_o,
  output logic [isl_pkg::ADDR_W-1:0]         own_address_o
);
  import isl_pkg::*;

  typedef enum logic [5:0] {
    ST_IDLE = 6'b000001,
    ST_ADDR = 6'b000010,
    ST_ADR2 = 6'b000100,
    ST_RX   = 6'b001000,
    ST_TX   = 6'b010000,
    ST_ACK  = 6'b100000
  } isl_state_t;

  typedef struct packed {
    isl_state_t       fsm;
    logic [3:0]       bitcnt;
    logic [7:0]       shift;      // receive_shift_reg
    logic [7:0]       rbuf;
    logic             receive_full_flag;
    logic             ov;
    logic             a10;
    logic             prior;      // full 10-bit match already seen
    logic             txm;
    logic             rel;
    logic             ack_drive;  // drive SDA low in ACK slot
    logic             addr_ack;
    logic             sda_out;
    logic             sda_oe;
    logic             scl_oe;
    logic             evt;
    logic [9:0]       oaddr;
    logic [7:0]       tbyte;
    logic             tfull;
    logic             mack_low;   // master ACK seen in TX ACK slot
  } isl_state_s_t;

  isl_state_s_t st;
  isl_state_s_t next_st;

  logic scl_s;
  logic scl_r;
  logic scl_f;
  logic sda_s;
  logic sda_r;
  logic sda_f;

  // Both pins cross into the system clock through two flops each
  isl_sync u_scl (
    .clk_i  (clk_i),
    .srst_i (srst_i),
    .pin_i  (scl_i),
    .level_o(scl_s),
    .rise_o (scl_r),
    .fall_o (scl_f)
  );
  isl_sync u_sda (
    .clk_i  (clk_i),
    .srst_i (srst_i),
    .pin_i  (sda_i),
    .level_o(sda_s),
    .rise_o (sda_r),
    .fall_o (sda_f)
  );

  logic start_c;
  logic stop_c;
  assign start_c = sda_f & scl_s;
  assign stop_c  = sda_r & scl_s;

  // Header of a 10-bit address: 11110 A9 A8, R_W ignored here
  function automatic logic hdr_match(input logic [7:0] b,
                                     input logic [9:0] a);
    hdr_match = (b[7:3] == HDR10_PATTERN) && (b[2:1] == a[9:8]);
  endfunction

  // Next-state logic; single process keeps all side effects in one place
  always_comb begin
    next_st     = st;
    next_st.evt = 1'b0;
    if (own_address_we_i) begin
      next_st.oaddr = own_address_reg_i;
    end
    if (transmit_we_i) begin
      next_st.tbyte = transmit_holding_reg_i;
      next_st.tfull = 1'b1;
    end
    if (clock_release_set_i) begin
      next_st.rel = 1'b1;
    end
    if (receive_read_i) begin
      next_st.receive_full_flag = 1'b0;
    end
    if (overflow_clear_i) begin
      next_st.ov = 1'b0;
    end
    // Release SCL only when software allows it
    next_st.scl_oe = ~next_st.rel;
    if (!module_enable_bit_i) begin
      next_st.fsm    = ST_IDLE;
      next_st.sda_oe = 1'b0;
      next_st.scl_oe = 1'b0;
      next_st.rel    = 1'b1;
      next_st.prior  = 1'b0;
    end else if (start_c) begin
      // Any Start, repeated or not, begins a new address byte
      next_st.fsm    = ST_ADDR;
      next_st.bitcnt = 4'h0;
      next_st.sda_oe = 1'b0;
      next_st.txm    = 1'b0;
    end else if (stop_c) begin
      next_st.fsm    = ST_IDLE;
      next_st.sda_oe = 1'b0;
      next_st.prior  = 1'b0;
    end else begin
      case (st.fsm)
        ST_IDLE: begin
          next_st.sda_oe = 1'b0;
        end
        ST_ADDR, ST_ADR2, ST_RX: begin
          if (scl_r) begin
            next_st.shift  = {st.shift[6:0], sda_s};
            next_st.bitcnt = st.bitcnt + 4'h1;
          end
          // Decide on the falling edge that closes bit eight
          if (scl_f && st.bitcnt == BITS_PER_BYTE) begin
            next_st.ack_drive = 1'b0;
            next_st.addr_ack  = 1'b0;
            next_st.fsm       = ST_ACK;
            next_st.txm       = 1'b0;
            if (st.fsm == ST_ADDR) begin
              next_st.addr_ack = 1'b1;
              if (!address_width_select_i) begin
                if (st.shift[7:1] == st.oaddr[6:0]) begin
                  next_st.ack_drive = 1'b1;
                  next_st.txm       = st.shift[0];
                end
              end else if (hdr_match(st.shift, st.oaddr)) begin
                if (!st.shift[0]) begin
                  next_st.ack_drive = 1'b1;
                  next_st.a10       = 1'b0;
                end else if (st.prior) begin
                  next_st.ack_drive = 1'b1;
                  next_st.txm       = 1'b1;
                end
              end
            end else if (st.fsm == ST_ADR2) begin
              next_st.addr_ack = 1'b1;
              if (st.shift == st.oaddr[7:0]) begin
                next_st.ack_drive = 1'b1;
                next_st.a10       = 1'b1;
                next_st.prior     = 1'b1;
              end else begin
                next_st.a10 = 1'b0;
              end
            end else begin
              // Data byte: double buffer into the receive register
              if (st.receive_full_flag) begin
                next_st.ov = 1'b1;
              end else begin
                next_st.rbuf      = st.shift;
                next_st.receive_full_flag       = 1'b1;
                next_st.ack_drive = ~st.ov;
              end
            end
            next_st.sda_oe  = next_st.ack_drive;
            next_st.sda_out = 1'b0;
            if (!next_st.ack_drive && next_st.addr_ack) begin
              next_st.sda_oe = 1'b0;
            end
          end
        end
        ST_TX: begin
          // Shift out on falling edges so SDA settles before SCL rises
          if (scl_f) begin
            if (st.bitcnt == BITS_PER_BYTE - 4'h1) begin
              next_st.sda_oe   = 1'b0;
              next_st.fsm      = ST_ACK;
              next_st.addr_ack = 1'b0;
            end else begin
              next_st.sda_oe = ~st.tbyte[3'h6 - st.bitcnt[2:0]];
              next_st.bitcnt = st.bitcnt + 4'h1;
            end
          end else if (st.bitcnt == 4'h0 && !scl_s) begin
            // First bit tracks the holding register while SCL is held low
            next_st.sda_oe = ~st.tbyte[BYTE_W-1];
          end
        end
        ST_ACK: begin
          if (scl_r && st.txm && !st.addr_ack) begin
            next_st.mack_low = ~sda_s;
          end
          // Ninth falling edge closes the ACK slot
          if (scl_f) begin
            next_st.sda_oe = 1'b0;
            next_st.bitcnt = 4'h0;
            if (st.addr_ack && !st.ack_drive) begin
              next_st.fsm = ST_IDLE;
            end else if (st.addr_ack && address_width_select_i &&
                         !st.a10 && !st.txm) begin
              next_st.fsm = ST_ADR2;
              next_st.evt = 1'b1;
            end else if (st.txm) begin
              next_st.evt = 1'b1;
              if (!st.addr_ack && !st.mack_low) begin
                next_st.fsm = ST_IDLE;
              end else begin
                next_st.fsm   = ST_TX;
                next_st.tfull = 1'b0;
                // Stretch until software loads data and releases
                if (!st.tfull || st.addr_ack) begin
                  next_st.rel    = 1'b0;
                  next_st.scl_oe = 1'b1;
                end
              end
            end else begin
              next_st.fsm = ST_RX;
              next_st.evt = 1'b1;
            end
          end
        end
        default: begin
          next_st.fsm = ST_IDLE;
        end
      endcase
    end
  end

  // Single register for all state
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      st          <= '0;
      st.fsm      <= ST_IDLE;
      st.rel      <= 1'b1;
      st.sda_out  <= 1'b0;
      st.shift    <= RESET_BYTE;
      st.rbuf     <= RESET_BYTE;
      st.tbyte    <= RESET_BYTE;
      st.oaddr    <= RESET_ADDR;
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from state flops; open drain drives low only
  assign scl_o                     = 1'b0;
  assign scl_oe_o                  = st.scl_oe;
  assign sda_o                     = 1'b0;
  assign sda_oe_o                  = st.sda_oe;
  assign receive_buffer_reg_o      = st.rbuf;
  assign receive_full_flag_o       = st.receive_full_flag;
  assign receive_overflow_flag_o   = st.ov;
  assign wide_address_match_flag_o = st.a10;
  assign slave_event_flag_o        = st.evt;
  assign transmit_mode_o           = st.txm;
  assign clock_release_bit_o       = st.rel;
  assign own_address_o             = st.oaddr;

  AST_NO_LOAD_WHEN_FULL: assert property (@(posedge clk_i)
    disable iff (srst_i)
    st.receive_full_flag && !receive_read_i |=> $stable(st.rbuf))
    else $error("receive buffer changed while full");
  AST_HOLD_SCL: assert property (@(posedge clk_i)
    disable iff (srst_i)
    !st.rel |-> st.scl_oe)
    else $error("SCL released while release bit clear");
  AST_IDLE_NO_SDA: assert property (@(posedge clk_i)
    disable iff (srst_i)
    st.fsm == ST_IDLE |-> !st.sda_oe)
    else $error("SDA driven in idle");
  AST_TX_CHANGE_ON_FALL: assert property (@(posedge clk_i)
    disable iff (srst_i)
    st.fsm == ST_TX && scl_s && !scl_f |=> $stable(st.sda_oe))
    else $error("transmit data changed while SCL high");
  AST_RX_LOAD: assert property (@(posedge clk_i)
    disable iff (srst_i)
    module_enable_bit_i && st.fsm == ST_RX && scl_f &&
    st.bitcnt == BITS_PER_BYTE && !st.receive_full_flag
    |=> st.receive_full_flag && st.rbuf == $past(st.shift))
    else $error("completed byte not moved into receive buffer");
  AST_ADDR_NO_LOAD: assert property (@(posedge clk_i)
    disable iff (srst_i)
    module_enable_bit_i && (st.fsm == ST_ADDR || st.fsm == ST_ADR2) &&
    scl_f && st.bitcnt == BITS_PER_BYTE && !receive_read_i
    |=> $stable(st.receive_full_flag) && $stable(st.rbuf))
    else $error("address byte disturbed the receive buffer");
  AST_MISMATCH_IDLE: assert property (@(posedge clk_i)
    disable iff (srst_i)
    module_enable_bit_i && st.fsm == ST_ACK && st.addr_ack &&
    !st.ack_drive && scl_f |=> st.fsm == ST_IDLE && !st.evt)
    else $error("mismatched address did not return to idle");
endmodule // isl_slave

// file: isl_bus_master.sv
`timescale 1ns/100ps
// Behavioural bus master; it only pulls lines low, pull-ups sit in the bench
module isl_bus_master (
  input  wire logic scl_i,
  input  wire logic sda_i,
  output logic      scl_dn_o,
  output logic      sda_dn_o,
  output logic      stuck_o
);
  // Both lines released at time zero
  initial begin
    scl_dn_o = 1'b0;
    sda_dn_o = 1'b0;
    stuck_o  = 1'b0;
  end
  // Bounded wait for SCL high; the slave may stretch the low phase
  task automatic wait_hi();
    int n;
    n = 0;
    while (!scl_i && n < 5000) begin
      #10;
      n++;
    end
    if (n >= 5000) stuck_o = 1'b1;
  endtask
  // One 200 ns bit: data set mid low phase, sampled mid high phase
  task automatic bit_io(input logic b, output logic s);
    scl_dn_o = 1'b1;
    #60 sda_dn_o = ~b;
    #60 scl_dn_o = 1'b0;
    wait_hi();
    #40 s = sda_i;
    #40;
  endtask
  // Start or repeated start: SDA falls while SCL is high
  task automatic start();
    scl_dn_o = 1'b1;
    #60 sda_dn_o = 1'b0;
    #60 scl_dn_o = 1'b0;
    wait_hi();
    #100 sda_dn_o = 1'b1;
    #100;
  endtask
  // Stop: SDA rises while SCL is high, then both lines stay released
  task automatic stop();
    scl_dn_o = 1'b1;
    #60 sda_dn_o = 1'b1;
    #60 scl_dn_o = 1'b0;
    wait_hi();
    #100 sda_dn_o = 1'b0;
    #100;
  endtask
  // Byte out MSB first; the ninth clock reads the answer (0 = ACK)
  task automatic wr_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(b[i], s);
    bit_io(1'b1, ack);
  endtask
  // Byte in MSB first, then our own answer on the ninth clock
  task automatic rd_byte(input logic nack, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, s);
      b[i] = s;
    end
    bit_io(nack, s);
  endtask
endmodule // isl_bus_master

// file: tb_top.sv
`timescale 1ns/100ps
// Self-checking bench: expected buffer contents queued per slave event
module tb_top;
  import isl_pkg::*;
  logic              clk_i, srst_i, en, a10, ack, in_rd;
  logic [ADDR_W-1:0] own, own_q;
  logic [BYTE_W-1:0] txd, rbuf, d, got, hold;
  logic [4:0]        pl;
  logic              scl_o, scl_oe, sda_o, sda_oe, m_scl, m_sda, stuck;
  logic              full, ov, wide, ev, txm, rel;
  wire               scl_w, sda_w;
  int                errors, tests_run, seed;
  logic [7:0]        q[$];

  // Open-drain wires with pull-ups
  assign scl_w = (scl_oe ? scl_o : 1'b1) & ~m_scl;
  assign sda_w = (sda_oe ? sda_o : 1'b1) & ~m_sda;

  // 40 MHz system clock
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  isl_slave uut (.clk_i(clk_i), .srst_i(srst_i), .scl_i(scl_w),
    .sda_i(sda_w), .scl_o(scl_o), .scl_oe_o(scl_oe), .sda_o(sda_o),
    .sda_oe_o(sda_oe), .module_enable_bit_i(en),
    .address_width_select_i(a10), .own_address_reg_i(own),
    .own_address_we_i(pl[0]), .transmit_holding_reg_i(txd),
    .transmit_we_i(pl[1]), .clock_release_set_i(pl[2]),
    .receive_read_i(pl[3]), .overflow_clear_i(pl[4]),
    .receive_buffer_reg_o(rbuf), .receive_full_flag_o(full),
    .receive_overflow_flag_o(ov), .wide_address_match_flag_o(wide),
    .slave_event_flag_o(ev), .transmit_mode_o(txm),
    .clock_release_bit_o(rel), .own_address_o(own_q));

  isl_bus_master m (.scl_i(scl_w), .sda_i(sda_w), .scl_dn_o(m_scl),
    .sda_dn_o(m_sda), .stuck_o(stuck));

  task automatic chk(input string nm, input logic [15:0] seen,
                     input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic clks(input int n);
    repeat (n) @(negedge clk_i);
  endtask

  // Strobes are one cycle wide, launched on the falling edge
  task automatic pulse(input logic [4:0] p);
    @(negedge clk_i) pl = p;
    @(negedge clk_i) pl = 5'h00;
  endtask

  // Byte from the master; settle to a falling edge before anything else
  task automatic wr(input logic [7:0] b, input logic e, input string nm);
    m.wr_byte(b, ack);
    @(negedge clk_i);
    chk(nm, {15'h0000, ack}, {15'h0000, e});
  endtask

  // Slave transmit: SCL must stay held until the byte is loaded
  task automatic tx();
    in_rd = 1'b1;
    fork
      m.rd_byte(1'b1, got);
      begin
        clks(40);
        chk("scl_hold", {15'h0000, scl_oe}, 16'h0001);
        chk("rel_bit", {15'h0000, rel}, 16'h0000);
        chk("tx_mode", {15'h0000, txm}, 16'h0001);
        d = 8'($random(seed));
        txd = d;
        pulse(5'h02);
        pulse(5'h04);
      end
    join
    in_rd = 1'b0;
    chk("tx_byte", {8'h00, got}, {8'h00, d});
  endtask

  // Each event pulse takes the oldest expected buffer value
  always @(negedge clk_i) begin
    if (!srst_i && ev === 1'b1) begin
      if (q.size() == 0) chk("extra_event", 16'h0001, 16'h0000);
      else chk("rx_buf", {8'h00, rbuf}, {8'h00, q.pop_front()});
    end
  end

  // Transmitted data may only move while SCL is low
  always @(sda_w) if (in_rd && scl_w) chk("sda_hold", 16'h1, 16'h0);

  // A stuck bus ends the run rather than hanging it
  always @(posedge stuck) begin
    errors++;
    wrap_up();
  end

  // Main sequence
  initial begin
    seed = 32'h2832;
    errors = 0;
    tests_run = 0;
    srst_i = 1'b1;
    en = 1'b1;
    a10 = 1'b0;
    own = 10'h000;
    txd = 8'h00;
    pl = 5'h00;
    in_rd = 1'b0;
    hold = 8'h00;
    clks(12);
    srst_i = 1'b0;
    chk("rel_reset", {15'h0000, rel}, 16'h0001);
    own = 10'h055;
    pulse(5'h01);
    chk("own_addr", {6'h00, own_q}, {6'h00, own});
    en = 1'b0;
    m.start();
    wr(8'hAA, 1'b1, "ack_off");
    m.stop();
    clks(1);
    en = 1'b1;
    m.start();
    wr(8'hAC, 1'b1, "ack_miss");
    m.stop();
    // Write: address, fresh byte, byte into full buffer, overflow reload
    m.start();
    q.push_back(hold);
    wr(8'hAA, 1'b0, "ack_addr");
    chk("full_addr", {15'h0000, full}, 16'h0000);
    d = 8'($random(seed));
    hold = d;
    q.push_back(d);
    wr(d, 1'b0, "ack_data");
    chk("full_data", {15'h0000, full}, 16'h0001);
    d = 8'($random(seed));
    q.push_back(hold);
    wr(d, 1'b1, "nack_full");
    pulse(5'h08);
    chk("ov_set", {15'h0000, ov}, 16'h0001);
    d = 8'($random(seed));
    hold = d;
    q.push_back(d);
    wr(d, 1'b1, "nack_ov");
    m.stop();
    pulse(5'h18);
    chk("ov_clear", {15'h0000, ov}, 16'h0000);
    // Read with the held byte left in the buffer
    m.start();
    q.push_back(hold);
    wr(8'hAB, 1'b0, "ack_rd");
    q.push_back(hold);
    tx();
    m.stop();
    // Ten-bit address, data byte, then repeated start for a read
    clks(1);
    a10 = 1'b1;
    own = 10'h2C5;
    pulse(5'h01);
    m.start();
    q.push_back(hold);
    wr(8'hF4, 1'b0, "ack_hdr");
    q.push_back(hold);
    wr(8'hC5, 1'b0, "ack_low");
    d = 8'($random(seed));
    hold = d;
    q.push_back(d);
    wr(d, 1'b0, "ack_d10");
    chk("wide_flag", {15'h0000, wide}, 16'h0001);
    pulse(5'h08);
    m.start();
    q.push_back(hold);
    wr(8'hF5, 1'b0, "ack_rs");
    q.push_back(hold);
    tx();
    m.stop();
    clks(20);
    chk("events_left", 16'(q.size()), 16'h0000);
    wrap_up();
  end
endmodule // tb_top
